// ===== common/link_pkg.sv
// Shared constants and types for the disk controller host link.
`default_nettype none
package link_pkg;
   // Clock period and the least host reset pulse, both in nanoseconds.
   localparam int CLK_NS = 40;
   localparam int INIT_NS = 1000;
   // Least reset pulse in clock cycles, rounded up.
   localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CYC);

   // Register word offsets on the host bus.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EVT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;

   // Field positions in the control register.
   localparam int CTRL_DMA = 0;
   localparam int CTRL_WIDE = 1;
   localparam int CTRL_EMU = 2;
   // Field positions in the command register.
   localparam int CMD_INIT = 0;
   localparam int CMD_NXM = 1;
   // Field positions in the status register.
   localparam int ST_DONE = 0;
   localparam int ST_ERR = 1;
   localparam int ST_DIR = 2;
   localparam int ST_INIT = 3;
   localparam int ST_FAULT = 4;
   // Field positions in the event and mask registers.
   localparam int EV_DONE = 0;
   localparam int EV_ERR = 1;

   // Values after reset.
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [3:0] SYNC_RST = 4'hf;

   // Steps of the controller initialization walk, in order.
   typedef enum logic [2:0] {
      STEP_CLEAR, STEP_SELFTEST, STEP_DIAG, STEP_VARS, STEP_HOME, STEP_BOOT
   } step_t;
endpackage : link_pkg
`default_nettype wire

// ===== common/link_if.sv
// Cable between the disk controller end and the host interface end.
`default_nettype none
interface link_if;
   // Lines driven by the host end, active low.
   logic host_reset_request_line_n;
   logic dma_select_line_n;
   logic word_width_select_line_n;
   // Lines driven by the controller end, active low.
   logic function_complete_line_n;
   logic transfer_direction_line_n;
   // Shared open-drain fault line, one driver pair from each end.
   logic ctrl_fault_out;
   logic ctrl_fault_oe;
   logic host_fault_out;
   logic host_fault_oe;
   logic fault_flag_line_n;

   // Wired level: low when either end pulls it low.
   assign fault_flag_line_n = ~((ctrl_fault_oe & ~ctrl_fault_out) | (host_fault_oe & ~host_fault_out));

   // Controller end.
   modport ctrl (
      input host_reset_request_line_n, dma_select_line_n, word_width_select_line_n, fault_flag_line_n,
      output function_complete_line_n, transfer_direction_line_n, ctrl_fault_out, ctrl_fault_oe
   );
   // Host interface end.
   modport host (
      output host_reset_request_line_n, dma_select_line_n, word_width_select_line_n,
      output host_fault_out, host_fault_oe,
      input function_complete_line_n, transfer_direction_line_n, fault_flag_line_n
   );
endinterface : link_if
`default_nettype wire

// ===== rtl/line_sync.sv
// Two-stage synchroniser for a group of incoming levels.
`default_nettype none
module line_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST = '1
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Raw and synchronised levels.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First and second stage.
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_t;
   sync_t s;
   sync_t next_s;

   // The first stage feeds only the second stage.
   always_comb
   begin
      next_s.first = d;
      next_s.second = s.first;
   end

   // Register both stages; reset to the negated level.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= {RST, RST};
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   assign q = s.second;
endmodule : line_sync
`default_nettype wire

// ===== rtl/ctrl_end.sv
// Disk controller end of the host link: status lines and initialization walk.
// Notes on behaviour
// R1: Error line asserted on error termination.
// R2: Error implies complete and direction lines asserted.
// R3: Error released by initialize or new command.
// R4: Host-driven fault causes error termination.
// R5: Host asserts initialize on any reset.
// R6: Initialize latched; masked during critical work.
// R7: Host initialize pulse lasts one microsecond.
// R8: Initialize walks clear, test, diag, vars, home, boot.
// R9: Success sets complete; failure sets complete and error.
// R10: Diagnostic mode leaves complete and error negated.
// R11: DMA select chooses DMA for buffer functions.
// R12: Host selects DMA only in emulation mode.
// R13: Word width line selects twelve-bit protocols.
// R14: Direction asserted toward host, negated otherwise.
// R15: Initialize forces direction line negated.
// R16: Complete low while busy; accept when ready.
// R17: Initialize accepted at any time, even busy.
// R18: Host-driven lines synchronised before use.
//
// The implementer's own choices: the APB slave port and the address map.
`default_nettype none
module ctrl_end (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Cable side.
   link_if.ctrl lk,
   // Initialization step handshake with the microcode core.
   input wire logic crit,
   input wire logic diag_switch,
   input wire logic step_ack,
   input wire logic step_fail,
   output logic step_req,
   output logic [2:0] step_code,
   // Command and function control from the core.
   input wire logic cmd_strobe,
   input wire logic cmd_dma,
   input wire logic dir_req,
   input wire logic func_end,
   input wire logic func_err,
   output logic cmd_taken,
   // Mode and state reports to the core.
   output logic use_dma,
   output logic twelve_bit,
   output logic busy,
   output logic diag_mode
);
   // Main control states.
   typedef enum logic [2:0] {S_STEP, S_WAIT, S_READY, S_BUSY, S_DIAG} cst_t;

   // All state of the controller end.
   typedef struct packed {
      cst_t st;
      link_pkg::step_t step;
      logic done_n;
      logic dir_n;
      logic err;
      logic init_pend;
      logic init_prev;
      logic init_fail;
      logic [1:0] own_echo;
      logic req;
      logic taken;
      logic dma;
      logic wide;
      logic busy;
      logic diag;
   } ctrl_t;

   // Reset starts the initialization walk with every line negated.
   localparam ctrl_t CTRL_RST = '{
      st: S_STEP, step: link_pkg::STEP_CLEAR, done_n: 1'b1, dir_n: 1'b1,
      err: 1'b0, init_pend: 1'b0, init_prev: 1'b0, init_fail: 1'b0, own_echo: 2'h0,
      req: 1'b0, taken: 1'b0, dma: 1'b0, wide: 1'b0, busy: 1'b1, diag: 1'b0
   };

   ctrl_t s;
   ctrl_t next_s;
   // Synchronised host lines: reset request, DMA select, width, fault.
   logic [3:0] sy;
   // Decoded synchronised levels, active high.
   logic init_act;
   logic dma_sel;
   logic wide_sel;
   logic fault_in;
   logic init_edge;

   // Advances to the following initialization step.
   function automatic link_pkg::step_t step_after(input link_pkg::step_t cur);
      link_pkg::step_t r;
      unique case (cur)
         link_pkg::STEP_CLEAR: r = link_pkg::STEP_SELFTEST;
         link_pkg::STEP_SELFTEST: r = link_pkg::STEP_DIAG;
         link_pkg::STEP_DIAG: r = link_pkg::STEP_VARS;
         link_pkg::STEP_VARS: r = link_pkg::STEP_HOME;
         link_pkg::STEP_HOME: r = link_pkg::STEP_BOOT;
         default: r = link_pkg::STEP_BOOT;
      endcase
      return r;
   endfunction : step_after

   // R18 two-flop sync
   line_sync #(
      .W(4),
      .RST(link_pkg::SYNC_RST)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d({lk.fault_flag_line_n, lk.word_width_select_line_n, lk.dma_select_line_n, lk.host_reset_request_line_n}),
      .q(sy)
   );

   // Active-high views of the synchronised host lines.
   always_comb
   begin
      init_act = ~sy[0];
      dma_sel = ~sy[1];
      wide_sel = ~sy[2];
      // Only a host pull counts; our own pull and its echo still in the synchroniser are excluded.
      fault_in = ~sy[3] & ~s.err & (s.own_echo == 2'h0);
      init_edge = init_act & ~s.init_prev;
   end

   // Next-state logic for the whole controller end.
   always_comb
   begin
      next_s = s;
      next_s.req = 1'b0;
      next_s.taken = 1'b0;
      next_s.init_prev = init_act;
      next_s.own_echo = {s.own_echo[0], s.err};
      // R13 width follows line
      next_s.wide = wide_sel;
      unique case (s.st)
         // One step of the initialization walk.
         S_STEP:
         begin
            if (s.step == link_pkg::STEP_CLEAR)
            begin
               // R8 clear lines first
               next_s.done_n = 1'b1;
               next_s.err = 1'b0;
               next_s.init_fail = 1'b0;
               next_s.step = step_after(s.step);
            end
            else
            begin
               // R8 request next step
               next_s.req = 1'b1;
               next_s.st = S_WAIT;
            end
         end
         // Wait for the core to finish the requested step.
         S_WAIT:
         begin
            if (step_ack)
            begin
               if (s.step == link_pkg::STEP_DIAG && diag_switch)
               begin
                  // R10 diagnostic stays silent
                  next_s.st = S_DIAG;
                  next_s.diag = 1'b1;
               end
               else if (s.step == link_pkg::STEP_BOOT)
               begin
                  // R9 report walk result
                  next_s.done_n = 1'b0;
                  next_s.err = s.init_fail | step_fail;
                  // R2 error forces direction
                  next_s.dir_n = ~(s.init_fail | step_fail);
                  next_s.busy = 1'b0;
                  next_s.st = S_READY;
               end
               else
               begin
                  next_s.init_fail = s.init_fail | step_fail;
                  next_s.step = step_after(s.step);
                  next_s.st = S_STEP;
               end
            end
         end
         // Idle with the complete line asserted.
         S_READY:
         begin
            // R16 accept when ready
            if (cmd_strobe && (s.dir_n || s.err))
            begin
               // R3 command clears error
               next_s.err = 1'b0;
               next_s.done_n = 1'b1;
               next_s.dir_n = 1'b1;
               next_s.taken = 1'b1;
               next_s.busy = 1'b1;
               // R11 DMA only when selected
               next_s.dma = cmd_dma & dma_sel;
               next_s.st = S_BUSY;
            end
         end
         // A function is running; complete stays negated.
         S_BUSY:
         begin
            // R14 direction from core
            next_s.dir_n = ~dir_req;
            if (fault_in || (func_end && func_err))
            begin
               // R4 host fault terminates
               // R1 error on termination
               next_s.err = 1'b1;
               // R2 complete and direction
               next_s.done_n = 1'b0;
               next_s.dir_n = 1'b0;
               next_s.busy = 1'b0;
               next_s.st = S_READY;
            end
            else if (func_end)
            begin
               next_s.done_n = 1'b0;
               next_s.dir_n = 1'b1;
               next_s.busy = 1'b0;
               next_s.st = S_READY;
            end
         end
         // Diagnostic mode holds until the next initialize.
         S_DIAG:
         begin
            next_s.done_n = 1'b1;
            next_s.err = 1'b0;
         end
         default:
         begin
            next_s.st = S_STEP;
            next_s.step = link_pkg::STEP_CLEAR;
         end
      endcase
      // R6 latch request until served
      if (init_edge)
      begin
         next_s.init_pend = 1'b1;
      end
      // R17 serve at any time crit is low
      if ((s.init_pend || init_edge) && !crit)
      begin
         next_s.init_pend = 1'b0;
         // R3 initialize clears error
         next_s.err = 1'b0;
         next_s.done_n = 1'b1;
         // R15 direction negated
         next_s.dir_n = 1'b1;
         next_s.req = 1'b0;
         next_s.taken = 1'b0;
         next_s.busy = 1'b1;
         next_s.diag = 1'b0;
         next_s.dma = 1'b0;
         next_s.st = S_STEP;
         next_s.step = link_pkg::STEP_CLEAR;
      end
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= CTRL_RST;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // Cable and core outputs straight from the state register.
   assign lk.function_complete_line_n = s.done_n;
   assign lk.transfer_direction_line_n = s.dir_n;
   assign lk.ctrl_fault_out = 1'b0;
   assign lk.ctrl_fault_oe = s.err;
   assign step_req = s.req;
   assign step_code = s.step;
   assign cmd_taken = s.taken;
   assign use_dma = s.dma;
   assign twelve_bit = s.wide;
   assign busy = s.busy;
   assign diag_mode = s.diag;
endmodule : ctrl_end
`default_nettype wire

// ===== rtl/host_end.sv
// Host interface end of the link, steered by software over APB.
`default_nettype none
module host_end (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt, high while an unmasked event is pending.
   output logic irq,
   // Cable side.
   link_if.host lk
);
   // All state of the host end.
   typedef struct packed {
      logic [2:0] ctrl;
      logic [1:0] mask;
      logic [1:0] ev;
      logic [link_pkg::CNT_W-1:0] cnt;
      logic fault;
      logic done_q;
      logic err_q;
      logic dir_q;
      logic [31:0] rdata;
      logic rdy;
      logic slverr;
      logic irq;
   } host_t;

   // Reset starts a full initialize pulse toward the controller.
   localparam host_t HOST_RST = '{
      ctrl: link_pkg::CTRL_RST, mask: link_pkg::MASK_RST, ev: 2'h0, cnt: link_pkg::INIT_CNT,
      fault: 1'b0, done_q: 1'b0, err_q: 1'b0, dir_q: 1'b0, rdata: 32'h0, rdy: 1'b0,
      slverr: 1'b0, irq: 1'b0
   };

   host_t s;
   host_t next_s;
   logic setup;
   logic access;
   logic [1:0] set_ev;

   // True for an offset that holds a register.
   function automatic logic mapped(input logic [7:0] a);
      return a == link_pkg::OFS_CTRL || a == link_pkg::OFS_CMD || a == link_pkg::OFS_STAT ||
         a == link_pkg::OFS_EVT || a == link_pkg::OFS_MASK;
   endfunction : mapped

   // Next-state logic for bus, events and cable drive.
   always_comb
   begin
      next_s = s;
      setup = psel & ~penable;
      access = psel & penable & s.rdy;
      // Sample the controller lines, active high.
      next_s.done_q = ~lk.function_complete_line_n;
      next_s.err_q = ~lk.fault_flag_line_n & ~s.fault;
      next_s.dir_q = ~lk.transfer_direction_line_n;
      set_ev = {next_s.err_q & ~s.err_q, next_s.done_q & ~s.done_q};
      // R7 pulse length count
      if (s.cnt != '0)
      begin
         next_s.cnt = s.cnt - 1'b1;
      end
      // R4 release once terminated
      if (next_s.done_q && next_s.dir_q)
      begin
         next_s.fault = 1'b0;
      end
      // Answer in the cycle after setup.
      next_s.rdy = setup;
      next_s.slverr = setup & ~mapped(paddr);
      next_s.rdata = 32'h0;
      if (setup && !pwrite)
      begin
         unique case (paddr)
            link_pkg::OFS_CTRL: next_s.rdata[2:0] = s.ctrl;
            link_pkg::OFS_STAT: next_s.rdata[4:0] = {s.fault, s.cnt != '0, s.dir_q, s.err_q, s.done_q};
            link_pkg::OFS_EVT: next_s.rdata[1:0] = s.ev;
            link_pkg::OFS_MASK: next_s.rdata[1:0] = s.mask;
            default: next_s.rdata = 32'h0;
         endcase
      end
      // Read of the event register clears only the bits it reported; a new event wins.
      if (access && !pwrite && paddr == link_pkg::OFS_EVT)
      begin
         next_s.ev = s.ev & ~s.rdata[1:0];
      end
      next_s.ev = next_s.ev | set_ev;
      if (access && pwrite)
      begin
         unique case (paddr)
            link_pkg::OFS_CTRL: next_s.ctrl = pwdata[2:0];
            link_pkg::OFS_MASK: next_s.mask = pwdata[1:0];
            link_pkg::OFS_CMD:
            begin
               // R5 software reset request
               if (pwdata[link_pkg::CMD_INIT])
               begin
                  next_s.cnt = link_pkg::INIT_CNT;
                  next_s.fault = 1'b0;
               end
               // R4 nonexistent memory fault
               if (pwdata[link_pkg::CMD_NXM] && !pwdata[link_pkg::CMD_INIT])
               begin
                  next_s.fault = 1'b1;
               end
            end
            default:
            begin
               next_s.ctrl = s.ctrl;
            end
         endcase
      end
      next_s.irq = |(next_s.ev & next_s.mask);
   end

   // State register, frozen while the enable is low.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= HOST_RST;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   // Ports from the state register.
   assign prdata = s.rdata;
   assign pready = s.rdy;
   assign pslverr = s.slverr;
   assign irq = s.irq;
   // R5 reset line while counting
   assign lk.host_reset_request_line_n = (s.cnt == '0);
   // R12 DMA gated by emulation
   assign lk.dma_select_line_n = ~(s.ctrl[link_pkg::CTRL_DMA] & s.ctrl[link_pkg::CTRL_EMU]);
   // R13 twelve-bit host
   assign lk.word_width_select_line_n = ~s.ctrl[link_pkg::CTRL_WIDE];
   assign lk.host_fault_out = 1'b0;
   assign lk.host_fault_oe = s.fault;
endmodule : host_end
`default_nettype wire

// ===== test/link_assertions.sv
// Concurrent checks on the cable between the controller end and the host end.
`default_nettype none
module link_assertions (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Cable lines.
   input wire logic host_reset_request_line_n,
   input wire logic function_complete_line_n,
   input wire logic transfer_direction_line_n,
   input wire logic ctrl_fault_out,
   input wire logic ctrl_fault_oe,
   input wire logic host_fault_out,
   input wire logic host_fault_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Counts the cycles the reset request has been low; reset holds the line low, so reset starts at one.
   logic [5:0] low_cnt;
   always_ff @(posedge clk)
   begin
      if (rst)
         low_cnt <= 6'h01;
      else if (host_reset_request_line_n)
         low_cnt <= 6'h00;
      else if (low_cnt != 6'h3f)
         low_cnt <= low_cnt + 6'h01;
   end

   a_err_with_done: assert property (ctrl_fault_oe |-> !function_complete_line_n && !transfer_direction_line_n)
      else $error("fault line without complete and direction");
   a_err_on_end: assert property ($rose(ctrl_fault_oe) |-> $fell(function_complete_line_n))
      else $error("fault raised outside a function end");
   a_err_release: assert property ($fell(ctrl_fault_oe) |-> function_complete_line_n)
      else $error("fault dropped without command or initialize");
   a_reset_idle: assert property ($past(rst) |-> function_complete_line_n && transfer_direction_line_n && !ctrl_fault_oe)
      else $error("controller lines not idle after reset");
   a_init_after_rst: assert property ($past(rst) |-> !host_reset_request_line_n)
      else $error("host end did not request initialize after reset");
   a_init_width: assert property ($rose(host_reset_request_line_n) |-> low_cnt >= 6'(link_pkg::INIT_CYC))
      else $error("initialize pulse too short");
   a_host_release: assert property (host_fault_oe && !function_complete_line_n && !transfer_direction_line_n |-> ##[1:3] !host_fault_oe)
      else $error("host kept pulling fault after error end");
   a_pull_low: assert property ((ctrl_fault_oe |-> !ctrl_fault_out) and (host_fault_oe |-> !host_fault_out))
      else $error("fault line driven high");
endmodule : link_assertions
`default_nettype wire

// ===== test/disk_ctrl_host_link_control_test.sv
// Bench for both link ends: APB on the host end, core signals on the controller end.
`default_nettype none
module disk_ctrl_host_link_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   // Clock, reset and enable, which is high except for one frozen command.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   // Controller core side.
   logic crit = 1'b0, diag_switch = 1'b0, step_ack = 1'b0, step_fail = 1'b0;
   logic cmd_strobe = 1'b0, cmd_dma = 1'b0, dir_req = 1'b0, func_end = 1'b0, func_err = 1'b0;
   logic step_req, cmd_taken, use_dma, twelve_bit, busy, diag_mode;
   logic [2:0] step_code;
   // APB master.
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq;
   // Counters, step that the core fails, and the log of requested steps.
   int num_errors = 0;
   int n_compared = 0;
   logic [2:0] fail_code = 3'h7;
   logic [2:0] steps[$];

   link_if lk ();
   ctrl_end ctrl_end_i (.clk, .rst, .ce, .lk, .crit, .diag_switch, .step_ack, .step_fail, .step_req, .step_code,
      .cmd_strobe, .cmd_dma, .dir_req, .func_end, .func_err, .cmd_taken, .use_dma, .twelve_bit, .busy, .diag_mode);
   host_end host_end_i (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .irq, .lk);
   link_assertions link_assertions_i (.clk, .rst, .host_reset_request_line_n(lk.host_reset_request_line_n),
      .function_complete_line_n(lk.function_complete_line_n),
      .transfer_direction_line_n(lk.transfer_direction_line_n), .ctrl_fault_out(lk.ctrl_fault_out),
      .ctrl_fault_oe(lk.ctrl_fault_oe), .host_fault_out(lk.host_fault_out), .host_fault_oe(lk.host_fault_oe));

   // Free-running clock.
   initial
   begin
      forever #20 clk = ~clk;
   end

   // Core model: acknowledges each step a cycle later and fails the chosen one.
   always @(posedge clk)
   begin
      step_ack <= step_req;
      step_fail <= step_req && step_code == fail_code;
      if (step_req)
         steps.push_back(step_code);
   end

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // Compares a seen value with the expected one.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // A wait that ran out ends the run.
   task automatic expire();
      check(32'h0, 32'h1);
      conclude();
   endtask : expire

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // One APB transfer; read data lands in rd and the error response is compared.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 16)
         expire();
      rd = prdata;
      check({31'h0, pslverr}, {31'h0, err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   // Reads a register and compares it.
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      check(rd, exp);
   endtask : rdc

   // Hands a command to the controller and compares whether it was taken.
   task automatic command(input logic dma, input logic taken);
      int i;
      cmd_strobe <= 1'b1;
      cmd_dma <= dma;
      @(posedge clk);
      cmd_strobe <= 1'b0;
      for (i = 0; i < 8 && cmd_taken !== 1'b1; i++)
         @(posedge clk);
      check({31'h0, i < 8}, {31'h0, taken});
   endtask : command

   // Ends the running function, with or without an error, and lets the lines settle.
   task automatic finish_fn(input logic err);
      func_end <= 1'b1;
      func_err <= err;
      @(posedge clk);
      func_end <= 1'b0;
      func_err <= 1'b0;
      tick(5);
   endtask : finish_fn

   // Waits until the initialize pulse is over and the controller is idle or in diagnostics.
   task automatic settle();
      int i;
      tick(8);
      for (i = 0; i < 400 && !(lk.host_reset_request_line_n === 1'b1 && (busy === 1'b0 || diag_mode === 1'b1)); i++)
         @(posedge clk);
      if (i == 400)
         expire();
      tick(3);
   endtask : settle

   // Issues an initialize from software and compares the status afterwards.
   task automatic init_run(input logic [31:0] exp);
      steps.delete();
      apb(1'b1, link_pkg::OFS_CMD, 32'h1, 1'b0);
      settle();
      rdc(link_pkg::OFS_STAT, exp);
   endtask : init_run

   // Main sequence.
   initial
   begin
      tick(16);
      rst <= 1'b0;
      settle();
      rdc(link_pkg::OFS_STAT, 32'h1);
      rdc(link_pkg::OFS_CTRL, 32'h0);
      rdc(link_pkg::OFS_MASK, 32'h0);
      rdc(link_pkg::OFS_EVT, 32'h1);
      rdc(link_pkg::OFS_EVT, 32'h0);
      apb(1'b0, 8'h14, 32'h0, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, link_pkg::OFS_STAT, 32'hffffffff, 1'b0);
      rdc(link_pkg::OFS_STAT, 32'h1);
      $display("Reset and register map done");
      init_run(32'h1);
      for (int s = 0; s < 5; s++)
         check(32'(steps[s]), 32'(s + 1));
      $display("Initialize walk done");
      rdc(link_pkg::OFS_EVT, 32'h1);
      apb(1'b1, link_pkg::OFS_MASK, 32'h2, 1'b0);
      command(1'b0, 1'b1);
      rdc(link_pkg::OFS_STAT, 32'h0);
      command(1'b0, 1'b0);
      finish_fn(1'b1);
      check({31'h0, irq}, 32'h1);
      rdc(link_pkg::OFS_STAT, 32'h7);
      rdc(link_pkg::OFS_EVT, 32'h3);
      tick(2);
      check({31'h0, irq}, 32'h0);
      command(1'b0, 1'b1);
      rdc(link_pkg::OFS_STAT, 32'h0);
      finish_fn(1'b0);
      check({31'h0, irq}, 32'h0);
      rdc(link_pkg::OFS_STAT, 32'h1);
      $display("Error and interrupt done");
      for (int v = 0; v < 8; v++)
      begin
         apb(1'b1, link_pkg::OFS_CTRL, 32'(v), 1'b0);
         tick(4);
         command(v != 7, 1'b1);
         check({31'h0, use_dma}, {31'h0, v[0] & v[2] & (v != 7)});
         check({31'h0, twelve_bit}, {31'h0, v[1]});
         finish_fn(1'b0);
      end
      $display("Mode lines done");
      // A frozen controller ignores a command.
      ce <= 1'b0;
      command(1'b0, 1'b0);
      ce <= 1'b1;
      command(1'b0, 1'b1);
      apb(1'b1, link_pkg::OFS_CMD, 32'h2, 1'b0);
      tick(4);
      finish_fn(1'b0);
      rdc(link_pkg::OFS_STAT, 32'h7);
      command(1'b0, 1'b1);
      finish_fn(1'b0);
      $display("Host fault done");
      dir_req <= 1'b1;
      command(1'b0, 1'b1);
      crit <= 1'b1;
      steps.delete();
      apb(1'b1, link_pkg::OFS_CMD, 32'h1, 1'b0);
      tick(40);
      check(32'(steps.size()), 32'h0);
      rdc(link_pkg::OFS_STAT, 32'h4);
      crit <= 1'b0;
      settle();
      rdc(link_pkg::OFS_STAT, 32'h1);
      dir_req <= 1'b0;
      $display("Masked initialize done");
      diag_switch <= 1'b1;
      init_run(32'h0);
      check({31'h0, diag_mode}, 32'h1);
      diag_switch <= 1'b0;
      init_run(32'h1);
      fail_code <= 3'h4;
      init_run(32'h7);
      fail_code <= 3'h7;
      init_run(32'h1);
      $display("Diagnostics and failure done");
      conclude();
   end
endmodule : disk_ctrl_host_link_control_test
`default_nettype wire
